// File: design/synth_cal_pkg.sv
// Function
// [R1] center frequency number register, read/write, reset zero
// [R2] band select bits 2:0, upper bits read zero
// [R3] cf calibration start bit self-clears, at most 25 us
// [R4] software writes reserved bits 6:5 as 1,0
// [R5] expose cf tuning state in bits 4:0
// [R6] delay-cell calibration runs 10 us, then clears
// [R7] status bit 7 shows synthesizer lock
// [R8] auto filter tuning on entering transceiver-off
// [R9] software retunes filter about every 5 minutes
// [R10] filter tune start bit set-only, self-clears within 25 us
// [R11] channel number selects only while band is zero
// [R12] decode band steps and base frequencies
// [R13] cf start raises unlock, completion raises lock
// [R14] lock clears pending unlock, and vice versa
// [R15] running start bit reads one, no restart
package synth_cal_pkg;

    // register offsets on the serial register port
    localparam logic [5:0] ADDR_LOCK_STATUS = 6'h11;
    localparam logic [5:0] ADDR_CF_NUMBER   = 6'h13;
    localparam logic [5:0] ADDR_CF_BAND     = 6'h14;
    localparam logic [5:0] ADDR_FILTER_TUNE = 6'h18;
    localparam logic [5:0] ADDR_CF_CAL      = 6'h1A;
    localparam logic [5:0] ADDR_DELAY_CAL   = 6'h1B;

    // field positions
    localparam int GO_BIT   = 7;
    localparam int LOCK_BIT = 7;

    // reset values
    localparam logic [7:0] CF_NUMBER_RESET   = 8'h00;
    localparam logic [2:0] BAND_RESET        = 3'h0;
    localparam logic [1:0] CF_RSVD_RESET     = 2'h2;
    localparam logic [4:0] CF_TUNE_RESET     = 5'h00;
    localparam logic [6:0] DELAY_RSVD_RESET  = 7'h40;
    localparam logic [6:0] FILTER_RSVD_RESET = 7'h50;
    localparam logic       STATUS_B6_RESET   = 1'b0;

    // calibration channel indices
    localparam int CH_CF     = 0;
    localparam int CH_DELAY  = 1;
    localparam int CH_FILTER = 2;
    localparam int NUM_CH    = 3;

    // timing
    localparam int CLK_MHZ          = 250;
    localparam int CF_CAL_MAX_US    = 25;
    localparam int DELAY_CAL_US     = 10;
    localparam int FILTER_TUNE_MAX_US = 25;
    localparam int CF_CAL_MAX_CYCLES    = CF_CAL_MAX_US * CLK_MHZ;
    localparam int DELAY_CAL_CYCLES     = DELAY_CAL_US * CLK_MHZ;
    localparam int FILTER_TUNE_MAX_CYCLES = FILTER_TUNE_MAX_US * CLK_MHZ;

    // band decode bases in 100 kHz units
    localparam logic [15:0] BASE_BAND1 = 16'd7690;
    localparam logic [15:0] BASE_BAND2 = 16'd8570;
    localparam logic [15:0] BASE_BAND3 = 16'd9030;
    localparam logic [15:0] BASE_BAND4 = 16'd7690;
    localparam logic [15:0] BASE_BAND5 = 16'd8330;
    localparam logic [15:0] COARSE_STEP = 16'd10;

    // calibration channel state, gray along idle -> run
    typedef enum logic [0:0] {
        CAL_IDLE = 1'b0,
        CAL_RUN  = 1'b1
    } cal_state_e;

endpackage

// File: design/synth_channel_and_calibration_ctrl.sv
`timescale 1ns/1ps
module synth_channel_and_calibration_ctrl #(
    parameter int CF_CAL_MAX_CYCLES      = synth_cal_pkg::CF_CAL_MAX_CYCLES,
    parameter int FILTER_TUNE_MAX_CYCLES = synth_cal_pkg::FILTER_TUNE_MAX_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    // register port
    input  wire logic [5:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    // analog handshakes
    input  wire logic       synthLock,
    input  wire logic [2:0] calDone,
    input  wire logic [4:0] cfTuneResult,
    input  wire logic       transceiverOffEntry,
    output logic      [2:0] calStart,
    output logic      [2:0] calBusy,
    // frequency selection
    output logic            useChannelNumber,
    output logic            freqValid,
    output logic     [15:0] synthFreq,
    // lock interrupt sources
    input  wire logic       lockIrqEnable,
    input  wire logic       unlockIrqEnable,
    input  wire logic       irqClear,
    output logic            lockPending,
    output logic            unlockPending
);

    ////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] centerFreqIndex;          // center frequency number
    logic [7:0] next_centerFreqIndex;
    logic [2:0] bandSelect;               // band select field
    logic [2:0] next_bandSelect;
    logic [1:0] cfRsvd;                   // cf reserved bits 6:5
    logic [1:0] next_cfRsvd;
    logic [4:0] cfTuneState;              // present cf tuning state
    logic [4:0] next_cfTuneState;
    logic [6:0] delayRsvd;                // delay-cell reserved bits
    logic [6:0] next_delayRsvd;
    logic [6:0] filterRsvd;               // filter reserved bits
    logic [6:0] next_filterRsvd;
    logic       statusB6;                 // status reserved bit 6
    logic       next_statusB6;
    logic       lockPrev;                 // lock level one cycle ago
    logic [2:0] goReq;                    // per-channel start request
    logic [2:0] calFinish;                // per-channel completion pulse

    // write hits on each register
    logic wrNumber;
    logic wrBand;
    logic wrCfCal;
    logic wrDelay;
    logic wrFilter;
    logic wrStatus;

    assign wrNumber = regWrite && (regAddr == synth_cal_pkg::ADDR_CF_NUMBER);
    assign wrBand   = regWrite && (regAddr == synth_cal_pkg::ADDR_CF_BAND);
    assign wrCfCal  = regWrite && (regAddr == synth_cal_pkg::ADDR_CF_CAL);
    assign wrDelay  = regWrite && (regAddr == synth_cal_pkg::ADDR_DELAY_CAL);
    assign wrFilter = regWrite && (regAddr == synth_cal_pkg::ADDR_FILTER_TUNE);
    assign wrStatus = regWrite && (regAddr == synth_cal_pkg::ADDR_LOCK_STATUS);

    // start requests: writing one to a go bit, or auto filter tuning
    assign goReq[synth_cal_pkg::CH_CF]     = wrCfCal && regWrData[synth_cal_pkg::GO_BIT];   // [R3]
    assign goReq[synth_cal_pkg::CH_DELAY]  = wrDelay && regWrData[synth_cal_pkg::GO_BIT];   // [R6]
    assign goReq[synth_cal_pkg::CH_FILTER] = (wrFilter && regWrData[synth_cal_pkg::GO_BIT])
                                           || transceiverOffEntry;                          // [R8]

    // next values of the stored fields
    always_comb begin
        next_centerFreqIndex = centerFreqIndex;
        next_bandSelect      = bandSelect;
        next_cfRsvd          = cfRsvd;
        next_cfTuneState     = cfTuneState;
        next_delayRsvd       = delayRsvd;
        next_filterRsvd      = filterRsvd;
        next_statusB6        = statusB6;
        if (wrNumber) begin
            next_centerFreqIndex = regWrData;                                    // [R1]
        end
        if (wrBand) begin
            next_bandSelect = regWrData[2:0];                                    // [R2]
        end
        if (wrCfCal) begin
            next_cfRsvd      = regWrData[6:5];
            next_cfTuneState = regWrData[4:0];                                   // [R5]
        end
        // calibration result overrides a same-cycle write
        if (calFinish[synth_cal_pkg::CH_CF]) begin
            next_cfTuneState = cfTuneResult;                                     // [R5]
        end
        if (wrDelay) begin
            next_delayRsvd = regWrData[6:0];
        end
        if (wrFilter) begin
            next_filterRsvd = regWrData[6:0];
        end
        if (wrStatus) begin
            next_statusB6 = regWrData[6];
        end
    end

    // register the stored fields
    always_ff @(posedge clock) begin
        if (!nrst) begin
            centerFreqIndex <= synth_cal_pkg::CF_NUMBER_RESET;
            bandSelect      <= synth_cal_pkg::BAND_RESET;
            cfRsvd          <= synth_cal_pkg::CF_RSVD_RESET;
            cfTuneState     <= synth_cal_pkg::CF_TUNE_RESET;
            delayRsvd       <= synth_cal_pkg::DELAY_RSVD_RESET;
            filterRsvd      <= synth_cal_pkg::FILTER_RSVD_RESET;
            statusB6        <= synth_cal_pkg::STATUS_B6_RESET;
            // follow the pin in reset so a locked synth gives no false edge
            lockPrev        <= synthLock;
        end else begin
            centerFreqIndex <= next_centerFreqIndex;
            bandSelect      <= next_bandSelect;
            cfRsvd          <= next_cfRsvd;
            cfTuneState     <= next_cfTuneState;
            delayRsvd       <= next_delayRsvd;
            filterRsvd      <= next_filterRsvd;
            statusB6        <= next_statusB6;
            lockPrev        <= synthLock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // calibration channels: cf, delay cell, filter
    genvar ch;
    generate
        for (ch = 0; ch < synth_cal_pkg::NUM_CH; ch++) begin : g_cal
            localparam int LIMIT = (ch == synth_cal_pkg::CH_CF)    ? CF_CAL_MAX_CYCLES :
                                   (ch == synth_cal_pkg::CH_DELAY) ? synth_cal_pkg::DELAY_CAL_CYCLES :
                                                                     FILTER_TUNE_MAX_CYCLES;
            localparam logic [15:0] LAST = 16'(LIMIT - 1);
            synth_cal_pkg::cal_state_e state;
            synth_cal_pkg::cal_state_e next_state;
            logic [15:0]               count;        // cycles spent in the run
            logic [15:0]               next_count;
            logic                      next_start;
            logic                      endNow;

            // delay cell runs a fixed time; others end on done or timeout
            assign endNow = (count == LAST)                                                     // [R6]
                          || (calDone[ch] && (ch != synth_cal_pkg::CH_DELAY));                  // [R3] [R10]
            assign calFinish[ch] = (state == synth_cal_pkg::CAL_RUN) && endNow;

            // sequence one calibration run
            always_comb begin
                next_state = state;
                next_count = count;
                next_start = 1'b0;
                case (state)
                    synth_cal_pkg::CAL_IDLE: begin
                        if (goReq[ch]) begin
                            next_state = synth_cal_pkg::CAL_RUN;
                            next_count = 16'h0000;
                            next_start = 1'b1;
                        end
                    end
                    synth_cal_pkg::CAL_RUN: begin
                        // further go writes are ignored while running
                        if (endNow) begin
                            next_state = synth_cal_pkg::CAL_IDLE;                       // [R15]
                        end else begin
                            next_count = count + 16'h0001;
                        end
                    end
                    default: begin
                        next_state = synth_cal_pkg::CAL_IDLE;
                    end
                endcase
            end

            // register the channel state
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    state        <= synth_cal_pkg::CAL_IDLE;
                    count        <= 16'h0000;
                    calStart[ch] <= 1'b0;
                    calBusy[ch]  <= 1'b0;
                end else begin
                    state        <= next_state;
                    count        <= next_count;
                    calStart[ch] <= next_start;
                    calBusy[ch]  <= (next_state == synth_cal_pkg::CAL_RUN);             // [R15]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // frequency selection decode
    logic        next_useChannelNumber;
    logic        next_freqValid;
    logic [15:0] next_synthFreq;
    logic [15:0] numberWide;

    assign numberWide = {8'h00, centerFreqIndex};

    // map band and number to 100 kHz units
    always_comb begin
        next_useChannelNumber = 1'b0;
        next_freqValid        = 1'b1;
        next_synthFreq        = 16'h0000;
        case (bandSelect)
            3'h0: next_useChannelNumber = 1'b1;                                  // [R11]
            3'h1: next_synthFreq = synth_cal_pkg::BASE_BAND1 + numberWide;       // [R12]
            3'h2: next_synthFreq = synth_cal_pkg::BASE_BAND2 + numberWide;       // [R12]
            3'h3: next_synthFreq = synth_cal_pkg::BASE_BAND3 + numberWide;       // [R12]
            3'h4: next_synthFreq = synth_cal_pkg::BASE_BAND4
                                 + 16'(numberWide * synth_cal_pkg::COARSE_STEP); // [R12]
            3'h5: next_synthFreq = synth_cal_pkg::BASE_BAND5
                                 + 16'(numberWide * synth_cal_pkg::COARSE_STEP); // [R12]
            default: next_freqValid = 1'b0;
        endcase
    end

    // register the decode
    always_ff @(posedge clock) begin
        if (!nrst) begin
            useChannelNumber <= 1'b1;
            freqValid        <= 1'b1;
            synthFreq        <= 16'h0000;
        end else begin
            useChannelNumber <= next_useChannelNumber;
            freqValid        <= next_freqValid;
            synthFreq        <= next_synthFreq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lock and unlock interrupt sources
    logic lockEvent;
    logic unlockEvent;
    logic next_lockPending;
    logic next_unlockPending;

    // cf start drops lock, completion regains it
    assign lockEvent   = lockIrqEnable
                       && ((synthLock && !lockPrev) || calFinish[synth_cal_pkg::CH_CF]);  // [R13]
    assign unlockEvent = unlockIrqEnable && !lockEvent
                       && ((!synthLock && lockPrev) || calStart[synth_cal_pkg::CH_CF]);   // [R13]

    // each event clears the other pending flag; a set beats irqClear
    always_comb begin
        next_lockPending   = lockPending;
        next_unlockPending = unlockPending;
        if (irqClear) begin
            next_lockPending   = 1'b0;
            next_unlockPending = 1'b0;
        end
        if (lockEvent) begin
            next_lockPending   = 1'b1;
            next_unlockPending = 1'b0;                                           // [R14]
        end
        if (unlockEvent) begin
            next_unlockPending = 1'b1;
            next_lockPending   = 1'b0;                                           // [R14]
        end
    end

    // register pending flags
    always_ff @(posedge clock) begin
        if (!nrst) begin
            lockPending   <= 1'b0;
            unlockPending <= 1'b0;
        end else begin
            lockPending   <= next_lockPending;
            unlockPending <= next_unlockPending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data
    logic [7:0] next_regRdData;

    // address decode for reads; unmapped reads zero
    always_comb begin
        next_regRdData = regRdData;
        if (regRead) begin
            if (regAddr == synth_cal_pkg::ADDR_LOCK_STATUS) begin
                next_regRdData = {synthLock, statusB6, 6'h00};                   // [R7]
            end else if (regAddr == synth_cal_pkg::ADDR_CF_NUMBER) begin
                next_regRdData = centerFreqIndex;                                // [R1]
            end else if (regAddr == synth_cal_pkg::ADDR_CF_BAND) begin
                next_regRdData = {5'h00, bandSelect};                            // [R2]
            end else if (regAddr == synth_cal_pkg::ADDR_FILTER_TUNE) begin
                next_regRdData = {calBusy[synth_cal_pkg::CH_FILTER], filterRsvd}; // [R10]
            end else if (regAddr == synth_cal_pkg::ADDR_CF_CAL) begin
                next_regRdData = {calBusy[synth_cal_pkg::CH_CF], cfRsvd, cfTuneState}; // [R5]
            end else if (regAddr == synth_cal_pkg::ADDR_DELAY_CAL) begin
                next_regRdData = {calBusy[synth_cal_pkg::CH_DELAY], delayRsvd};  // [R6]
            end else begin
                next_regRdData = 8'h00;
            end
        end
    end

    // register read data
    always_ff @(posedge clock) begin
        if (!nrst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= next_regRdData;
        end
    end

endmodule

// File: tb/synth_channel_and_calibration_ctrl_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// port-level properties of the synthesizer control block
module synth_cal_chk #(
    parameter int CF_CAL_MAX_CYCLES      = 20,
    parameter int FILTER_TUNE_MAX_CYCLES = 20
) (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic [5:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    input wire logic       synthLock,
    input wire logic [2:0] calDone,
    input wire logic [2:0] calStart,
    input wire logic [2:0] calBusy,
    input wire logic       useChannelNumber,
    input wire logic       lockIrqEnable,
    input wire logic       unlockIrqEnable,
    input wire logic       irqClear,
    input wire logic       lockPending,
    input wire logic       unlockPending
);
    localparam int CF_LIM = CF_CAL_MAX_CYCLES + 1;      // busy span allowed for cf
    localparam int FT_LIM = FILTER_TUNE_MAX_CYCLES + 1; // busy span allowed for filter
    logic [11:0] dlyCnt;      // cycles the delay run has been busy
    logic [11:0] next_dlyCnt;
    logic [15:0] cfCnt;       // cycles the cf run has been busy
    logic [15:0] next_cfCnt;
    // busy counters, cleared in reset and when idle
    always_comb begin
        next_dlyCnt = (nrst && calBusy[1]) ? dlyCnt + 12'h001 : 12'h000;
        next_cfCnt  = (nrst && calBusy[0]) ? cfCnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clock) begin
        dlyCnt <= next_dlyCnt;
        cfCnt  <= next_cfCnt;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    // accepted cf launch write
    sequence cfGo;
        regWrite && regAddr == synth_cal_pkg::ADDR_CF_CAL && regWrData[7] && !calBusy[0];
    endsequence
    // band write followed by a quiet cycle
    sequence bandSet;
        regWrite && regAddr == synth_cal_pkg::ADDR_CF_BAND ##1 !(regWrite && regAddr == synth_cal_pkg::ADDR_CF_BAND);
    endsequence
    AST_CF_LAUNCH: assert property (cfGo |=> calStart[0] && calBusy[0])
        else $error("cf launch missing");
    AST_NO_RESTART: assert property (calBusy[0] |=> !calStart[0])
        else $error("cf restarted while running");
    AST_CF_DONE: assert property (calBusy[0] && !calStart[0] && calDone[0] |=> !calBusy[0])
        else $error("cf busy after done");
    AST_CF_BOUND: assert property (cfCnt <= CF_LIM)
        else $error("cf run too long");
    AST_DELAY_LEN: assert property ($fell(calBusy[1]) && $past(nrst) |-> dlyCnt == synth_cal_pkg::DELAY_CAL_CYCLES)
        else $error("delay run length wrong");
    AST_FILTER_END: assert property (calStart[2] |-> ##[1:FT_LIM] !calBusy[2])
        else $error("filter run too long");
    AST_LOCK_READ: assert property (regRead && regAddr == synth_cal_pkg::ADDR_LOCK_STATUS && $stable(synthLock)
        |=> regRdData[7] == $past(synthLock)) else $error("lock bit read wrong");
    AST_BAND_MODE: assert property (bandSet |=> useChannelNumber == ($past(regWrData[2:0], 2) == 3'h0))
        else $error("channel number mode wrong");
    AST_UNLOCK_EVT: assert property (calStart[0] && unlockIrqEnable && !$rose(synthLock)
        |=> unlockPending && !lockPending) else $error("unlock event lost");
    AST_LOCK_EVT: assert property ($rose(synthLock) && lockIrqEnable && $past(nrst)
        |=> lockPending && !unlockPending) else $error("lock event lost");
    AST_CLEAR: assert property (irqClear && $stable(synthLock) && !calStart[0] && !calBusy[0]
        && !$fell(calBusy[0]) |=> !lockPending && !unlockPending) else $error("pending not cleared");
endmodule
bind synth_channel_and_calibration_ctrl synth_cal_chk #(
    .CF_CAL_MAX_CYCLES(CF_CAL_MAX_CYCLES), .FILTER_TUNE_MAX_CYCLES(FILTER_TUNE_MAX_CYCLES)
) u_chk (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .synthLock(synthLock), .calDone(calDone), .calStart(calStart),
    .calBusy(calBusy), .useChannelNumber(useChannelNumber), .lockIrqEnable(lockIrqEnable),
    .unlockIrqEnable(unlockIrqEnable), .irqClear(irqClear), .lockPending(lockPending),
    .unlockPending(unlockPending));

// File: tb/synth_channel_and_calibration_ctrl_tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench, register contents modelled in mdl
module synth_channel_and_calibration_ctrl_tb_top;
    localparam int CALMAX = 20;  // shortened cf and filter bound
    logic        clock, nrst, regWrite, regRead, synthLock, transceiverOffEntry;
    logic        useChannelNumber, freqValid, lockIrqEnable, unlockIrqEnable, irqClear;
    logic        lockPending, unlockPending;
    logic [5:0]  regAddr;
    logic [7:0]  regWrData, regRdData, num;
    logic [2:0]  calDone, calStart, calBusy;
    logic [4:0]  cfTuneResult, tune;
    logic [15:0] synthFreq;
    logic [31:0] lfsrState;      // random source
    int          fail_count, n_compared, n;
    int          mdl [64];       // expected register reads
    logic [5:0]  addrList [7] = '{6'h11, 6'h13, 6'h14, 6'h18, 6'h1A, 6'h1B, 6'h05};

    synth_channel_and_calibration_ctrl #(.CF_CAL_MAX_CYCLES(CALMAX), .FILTER_TUNE_MAX_CYCLES(CALMAX)) u_synth_channel_and_calibration_ctrl (
        .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .synthLock(synthLock), .calDone(calDone),
        .cfTuneResult(cfTuneResult), .transceiverOffEntry(transceiverOffEntry), .calStart(calStart),
        .calBusy(calBusy), .useChannelNumber(useChannelNumber), .freqValid(freqValid), .synthFreq(synthFreq),
        .lockIrqEnable(lockIrqEnable), .unlockIrqEnable(unlockIrqEnable), .irqClear(irqClear),
        .lockPending(lockPending), .unlockPending(unlockPending));

    ////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // next random word
    function automatic logic [31:0] lfsr();
        lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
        return lfsrState;
    endfunction
    // frequency in 100 kHz units for bands 1 to 5, zero for other band codes
    function automatic logic [15:0] expFreq(input int b, input logic [7:0] v);
        case (b)
            1: return synth_cal_pkg::BASE_BAND1 + 16'(v);
            2: return synth_cal_pkg::BASE_BAND2 + 16'(v);
            3: return synth_cal_pkg::BASE_BAND3 + 16'(v);
            4: return synth_cal_pkg::BASE_BAND4 + synth_cal_pkg::COARSE_STEP * 16'(v);
            5: return synth_cal_pkg::BASE_BAND5 + synth_cal_pkg::COARSE_STEP * 16'(v);
            default: return 16'h0000;
        endcase
    endfunction
    // compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clock);
    endtask
    // one-cycle pulses on calDone, transceiverOffEntry or irqClear
    task automatic pulse(input int which);
        @(negedge clock);
        if (which < 3) calDone[which] = 1'b1;
        else if (which == 3) transceiverOffEntry = 1'b1;
        else irqClear = 1'b1;
        @(negedge clock);
        calDone = 3'h0;
        transceiverOffEntry = 1'b0;
        irqClear = 1'b0;
    endtask
    // register write, model follows the access kinds
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        if (a == 6'h13) mdl[a] = d;
        else if (a == 6'h14) mdl[a] = d & 8'h07;
        else if (a == 6'h11) mdl[a] = d & 8'h40;
        else if (a inside {6'h18, 6'h1A, 6'h1B}) mdl[a] = d | (mdl[a] & 8'h80);
    endtask
    // register read compared with the model
    task automatic rd(input logic [5:0] a);
        @(negedge clock);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        check("register read", {8'h00, regRdData}, 16'((a == 6'h11) ? (mdl[a] | {synthLock, 7'h00}) : mdl[a]));
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {fail_count, n_compared} = 0;
        lfsrState = 32'h0000CB60;
        {nrst, regWrite, regRead, transceiverOffEntry, irqClear, lockIrqEnable, unlockIrqEnable} = 7'h00;
        {regAddr, regWrData, calDone, cfTuneResult} = 22'h000000;
        synthLock = 1'b1;
        foreach (mdl[i]) mdl[i] = 0;
        mdl[6'h1A] = 8'h40;
        mdl[6'h1B] = 8'h40;
        mdl[6'h18] = 8'h50;
        tick(4);
        nrst = 1'b1;
        foreach (addrList[i]) rd(addrList[i]);
        wr(6'h05, 8'hA5);
        rd(6'h05);
        // every band code with a random number
        for (int b = 0; b < 8; b++) begin
            num = 8'(lfsr());
            wr(6'h13, num);
            wr(6'h14, {5'h1F, 3'(b)});
            tick(2);
            check("channel mode", 16'(useChannelNumber), 16'(b == 0));
            check("freq valid", 16'(freqValid), 16'(b < 6));
            if (b < 6) check("synth freq", synthFreq, expFreq(b, num));
            rd(6'h13);
            rd(6'h14);
        end
        // cf calibration ended by done, then by the bound
        lockIrqEnable = 1'b1;
        unlockIrqEnable = 1'b1;
        tune = 5'(lfsr());
        wr(6'h1A, {3'b010, tune});
        wr(6'h1A, {3'b110, tune});
        rd(6'h1A);
        check("unlock pending", {15'h0000, unlockPending}, 16'h0001);
        wr(6'h1A, {3'b110, tune});
        cfTuneResult = 5'(lfsr());
        pulse(0);
        mdl[6'h1A] = {3'b010, cfTuneResult};
        rd(6'h1A);
        check("lock after cf", {14'h0000, lockPending, unlockPending}, 16'h0002);
        pulse(4);
        check("cleared", {14'h0000, lockPending, unlockPending}, 16'h0000);
        wr(6'h1A, {3'b110, cfTuneResult});
        tick(CALMAX + 3);
        mdl[6'h1A] = mdl[6'h1A] & 8'h7F;
        rd(6'h1A);
        // delay cell run length
        wr(6'h1B, 8'hC0);
        n = 0;
        while (calBusy[1] === 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        check("delay length", 16'(n), 16'(synth_cal_pkg::DELAY_CAL_CYCLES));
        mdl[6'h1B] = 8'h40;
        rd(6'h1B);
        // filter tuning, automatic then manual
        pulse(3);
        mdl[6'h18] = 8'hD0;
        rd(6'h18);
        pulse(2);
        mdl[6'h18] = 8'h50;
        rd(6'h18);
        wr(6'h18, 8'hD0);
        rd(6'h18);
        tick(CALMAX + 3);
        mdl[6'h18] = 8'h50;
        rd(6'h18);
        // lock status and events
        synthLock = 1'b0;
        tick(2);
        check("unlock event", {14'h0000, lockPending, unlockPending}, 16'h0001);
        wr(6'h11, 8'hFF);
        rd(6'h11);
        synthLock = 1'b1;
        tick(2);
        check("lock event", {14'h0000, lockPending, unlockPending}, 16'h0002);
        rd(6'h11);
        pulse(4);
        lockIrqEnable = 1'b0;
        synthLock = 1'b0;
        tick(2);
        synthLock = 1'b1;
        tick(2);
        check("masked lock", {15'h0000, lockPending}, 16'h0000);
        test_done();
    end
endmodule
